//--- design/pulse_channel_monitor.sv
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module pulse_channel_monitor
  import pcm_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MS_CYCLES_DEF,
  parameter int unsigned FREQ_TO_CYC = MS_CYCLES_DEF * S_MS
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [3:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  input wire logic pulse_in,
  input wire logic peak_view_key,
  input wire logic reset_key,
  input wire logic channel_select_key,
  input wire logic ch1_pulse,
  output logic [1:0] relay_out,
  output logic alarm_out,
  output logic [2:0] limit_led,
  output logic high_peak_prompt,
  output logic low_peak_prompt,
  output logic over_range
);

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    mode_t mode;
    logic flo;
    logic [2:0] cmode;
    logic man;
    logic [3:0] filt;
    logic [23:0] tb;
    logic [23:0] scal;
    logic [15:0] divi;
    logic [23:0] preset;
    logic [23:0] dly;
    logic [23:0] db;
    logic [2:0][23:0] sp;
    logic [17:0] ms_cnt;
    logic [9:0] sec_ms;
    logic [23:0] rwin;
    logic [23:0] racc;
    logic [23:0] rate;
    logic [15:0] fwin;
    logic [23:0] facc;
    logic [23:0] rpm;
    logic [16:0] frac;
    logic [15:0] pre;
    logic [31:0] per;
    dstate_t dst;
    logic [32:0] rem;
    logic [35:0] quot;
    logic [31:0] dvs;
    logic [5:0] dit;
    logic [23:0] freq;
    logic [23:0] cnt;
    logic dly_on;
    logic [23:0] dly_cnt;
    logic [23:0] hi;
    logic [23:0] lo;
    logic vlo;
    logic [2:0] lim;
    logic [31:0] rdata;
  } state_t;
  state_t s_r;
  state_t s_nxt;
  // {inc, frac}: fixed point in 1e-5 units, whole units carried out
  function automatic logic [23:0] scale_step(input logic [16:0] f,
                                             input logic [23:0] st);
    logic [23:0] sum;
    logic [6:0] q;
    logic [23:0] prod;
    sum = {7'h00, f} + st;
    q = 7'(sum / SC_ONE);
    prod = {17'h0_0000, q} * SC_ONE;
    return {q, 17'(sum - prod)};
  endfunction
  // saturating add, sticks at the over-range marker
  function automatic logic [23:0] satadd(input logic [23:0] a,
                                         input logic [23:0] b);
    logic [24:0] s;
    s = {1'b0, a} + {1'b0, b};
    return (s > {1'b0, OVR}) ? OVR : s[23:0];
  endfunction
  function automatic logic [23:0] clampv(input logic [31:0] x,
                                         input logic [23:0] lo_lim);
    if (x > {8'h00, VAL_MAX}) return VAL_MAX;
    if (x[23:0] < lo_lim) return lo_lim;
    return x[23:0];
  endfunction
  function automatic logic [5:0] filt_s(input logic [3:0] i);
    case (i)
      4'h0: return 6'h01;
      4'h1: return 6'h02;
      4'h2: return 6'h04;
      4'h3: return 6'h06;
      4'h4: return 6'h0A;
      4'h5: return 6'h0F;
      4'h6: return 6'h14;
      4'h7: return 6'h1E;
      default: return 6'h3C;
    endcase
  endfunction
  logic edge_in, pv_held, rst_edge, ms_tick, sec_tick, down, counted;
  logic scal_on, hit, lclr, crst, wrap, dcnt, trip, rel;
  logic [15:0] div_eff, fms;
  logic [23:0] ss, inc, eff_tb, pv, c, rate_out, sp_i, fmax;
  logic [32:0] sh;
  logic [31:0] rdm, t;
  always_comb begin
    s_nxt = s_r;
    lclr = 1'b0;
    crst = 1'b0;
    wrap = 1'b0;
    trip = 1'b0;
    rel = 1'b0;
    c = '0;
    sp_i = '0;
    sh = '0;
    t = '0;
    // two-flop synchronisers, third stage only for edges
    s_nxt.s1 = {channel_select_key, reset_key, peak_view_key, pulse_in};
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    edge_in = s_r.s2[0] & ~s_r.s3[0];
    pv_held = s_r.s2[1];
    rst_edge = s_r.s2[2] & ~s_r.s3[2];
    down = s_r.cmode >= CM_DOWN;
    dcnt = (s_r.mode == M_COUNT) && down;
    case (s_r.mode)
      M_RATE: pv = s_r.rate;
      M_RPM: pv = s_r.rpm;
      M_FREQ: pv = s_r.freq;
      default: pv = s_r.cnt;
    endcase
    rate_out = (s_r.mode == M_FREQ) ? s_r.freq : s_r.rate;
    // crystal ms and second ticks
    ms_tick = s_r.ms_cnt == 18'(MS_CYCLES - 1);
    s_nxt.ms_cnt = ms_tick ? '0 : s_r.ms_cnt + 18'h0_0001;
    sec_tick = ms_tick && (s_r.sec_ms == SEC_LAST);
    if (ms_tick) s_nxt.sec_ms = sec_tick ? '0 : s_r.sec_ms + 10'h001;
    // prescale or scale each input edge
    scal_on = s_r.scal != '0;
    div_eff = (s_r.divi == '0) ? DIV_RST : s_r.divi;
    hit = (s_r.pre + 16'h0001) >= div_eff;
    counted = edge_in && (scal_on || hit);
    if (edge_in && !scal_on) s_nxt.pre = hit ? '0 : s_r.pre + 16'h0001;
    ss = scale_step(s_r.frac, scal_on ? s_r.scal : SC_ONE);
    inc = counted ? {17'h0_0000, ss[23:17]} : '0;
    if (counted) s_nxt.frac = ss[16:0];
    // rate window; in rpm mode capped to the filter window
    fms = 16'({10'h000, filt_s(s_r.filt)} * MS_PER_S);
    eff_tb = s_r.tb;
    if (s_r.mode == M_RPM && s_r.tb >= {8'h00, fms}) begin
      eff_tb = {8'h00, fms};
    end
    s_nxt.racc = satadd(s_r.racc, inc);
    if (ms_tick) begin
      s_nxt.rwin = s_r.rwin + 24'h00_0001;
      if (s_r.rwin + 24'h00_0001 >= eff_tb) begin
        s_nxt.rate = s_nxt.racc;
        s_nxt.racc = '0;
        s_nxt.rwin = '0;
      end
    end
    // rpm: revolutions over the filter window, times 60 over seconds
    s_nxt.facc = satadd(s_r.facc, inc);
    if (ms_tick) begin
      s_nxt.fwin = s_r.fwin + 16'h0001;
      if (s_r.fwin + 16'h0001 >= fms) begin
        t = ({8'h00, s_nxt.facc} * 32'h0000_003C) /
            {26'h000_0000, filt_s(s_r.filt)};
        s_nxt.rpm = (t > {8'h00, OVR}) ? OVR : t[23:0];
        if (s_nxt.facc == OVR) s_nxt.rpm = OVR;
        s_nxt.facc = '0;
        s_nxt.fwin = '0;
      end
    end
    // period gate; a stalled input times out to zero
    if (s_r.per != FREQ_TO_CYC) begin
      s_nxt.per = s_r.per + 32'h0000_0001;
    end else begin
      s_nxt.freq = '0;
    end
    if (edge_in) begin
      s_nxt.per = 32'h0000_0001;
      if (s_r.per != FREQ_TO_CYC && s_r.dst == D_IDLE) begin
        s_nxt.dvs = s_r.per;
        s_nxt.rem = '0;
        s_nxt.quot = s_r.flo ? FNUM_LO : FNUM_HI;
        s_nxt.dit = '0;
        s_nxt.dst = D_RUN;
      end
    end
    // restoring divider, one quotient bit per clock
    fmax = s_r.flo ? LO_MAX : HI_MAX;
    case (s_r.dst)
      D_RUN: begin
        sh = {s_r.rem[31:0], s_r.quot[35]};
        s_nxt.quot = {s_r.quot[34:0], 1'b0};
        s_nxt.rem = sh;
        if (sh >= {1'b0, s_r.dvs}) begin
          s_nxt.rem = sh - {1'b0, s_r.dvs};
          s_nxt.quot[0] = 1'b1;
        end
        s_nxt.dit = s_r.dit + 6'h01;
        if (s_r.dit == DIV_LAST) begin
          s_nxt.dst = D_IDLE;
          if (s_nxt.quot > {12'h000, fmax}) begin
            s_nxt.freq = OVR;
          end else if (s_r.flo && s_nxt.quot[23:0] < LO_MIN) begin
            s_nxt.freq = '0;
          end else begin
            s_nxt.freq = s_nxt.quot[23:0];
          end
        end
      end
      default: ;
    endcase
    // register writes
    if (wr_en) begin
      case (addr)
        A_CTRL: begin
          s_nxt.mode = mode_t'(wr_data[CF_MODE+:2]);
          s_nxt.flo = wr_data[CF_FLO] & ~ch1_pulse;
          if (wr_data[CF_CM+:3] <= CM_MAX) begin
            s_nxt.cmode = wr_data[CF_CM+:3];
          end
          s_nxt.man = wr_data[CF_MAN];
          if (wr_data[CF_FILT+:4] <= FILT_MAX) begin
            s_nxt.filt = wr_data[CF_FILT+:4];
          end
          lclr = wr_data[CF_LCLR];
          crst = 1'b1;
        end
        A_TB: s_nxt.tb = clampv(wr_data, TB_MIN);
        A_SCAL: s_nxt.scal = clampv(wr_data, '0);
        A_DIV: s_nxt.divi = wr_data[15:0];
        A_PRE: s_nxt.preset = clampv(wr_data, '0);
        A_DLY: s_nxt.dly = clampv(wr_data, DLY_RST);
        A_DB: s_nxt.db = clampv(wr_data, '0);
        A_SP0, A_SP1, A_SP2: begin
          s_nxt.sp[2'(addr - A_SP0)] = clampv(wr_data, 24'h00_0001);
        end
        default: ;
      endcase
    end
    if (ch1_pulse) s_nxt.flo = 1'b0;
    // counter modes 0-2 up, 3-5 down
    if (s_r.mode == M_COUNT && counted && !s_r.dly_on) begin
      if (!down) begin
        c = satadd(s_r.cnt, inc);
        s_nxt.cnt = c;
        if (s_r.cmode == 3'h1 && c >= s_r.preset) begin
          s_nxt.cnt = '0;
          wrap = 1'b1;
        end else if (s_r.cmode == 3'h2 && c >= s_r.preset) begin
          s_nxt.cnt = s_r.preset;
          s_nxt.dly_on = 1'b1;
          s_nxt.dly_cnt = '0;
        end
      end else begin
        c = (s_r.cnt > inc) ? s_r.cnt - inc : '0;
        s_nxt.cnt = c;
        if (c == '0 && s_r.cmode == 3'h4) begin
          s_nxt.cnt = s_r.preset;
          wrap = 1'b1;
        end else if (c == '0 && s_r.cmode == 3'h5) begin
          s_nxt.dly_on = 1'b1;
          s_nxt.dly_cnt = '0;
        end
      end
    end
    if (s_r.dly_on && sec_tick) begin
      s_nxt.dly_cnt = s_r.dly_cnt + 24'h00_0001;
      if (s_r.dly_cnt + 24'h00_0001 >= s_r.dly) begin
        s_nxt.dly_on = 1'b0;
        s_nxt.cnt = down ? s_r.preset : '0;
        wrap = 1'b1;
      end
    end
    // manual count reset: select key held, reset pressed
    if (rst_edge && s_r.s2[3] && !pv_held) crst = 1'b1;
    if (crst) begin
      s_nxt.cnt = (s_nxt.cmode >= CM_DOWN) ? s_nxt.preset : '0;
      s_nxt.dly_on = 1'b0;
    end
    // limits: clear first so a trip in the same cycle wins
    for (int i = 0; i < 3; i++) begin
      sp_i = s_r.sp[i];
      trip = dcnt ? (pv <= sp_i) : (pv > sp_i);
      rel = dcnt ? ({1'b0, pv} > {1'b0, sp_i} + {1'b0, s_r.db})
                 : ({1'b0, pv} + {1'b0, s_r.db} < {1'b0, sp_i});
      if (lclr || crst) s_nxt.lim[i] = 1'b0;
      if (!s_r.man && (rel || wrap)) s_nxt.lim[i] = 1'b0;
      if (trip) s_nxt.lim[i] = 1'b1;
    end
    // peaks follow the live value in every mode
    if (pv > s_r.hi) s_nxt.hi = pv;
    if (pv < s_r.lo) s_nxt.lo = pv;
    if (s_r.s2[1] && !s_r.s3[1]) s_nxt.vlo = ~s_r.vlo;
    if (rst_edge && pv_held) begin
      if (s_r.vlo) begin
        s_nxt.lo = pv;
      end else begin
        s_nxt.hi = pv;
      end
    end
    // read mux, data valid only the cycle after the strobe
    rdm = '0;
    case (addr)
      A_CTRL: begin
        rdm[CF_MODE+:2] = s_r.mode;
        rdm[CF_FLO] = s_r.flo;
        rdm[CF_CM+:3] = s_r.cmode;
        rdm[CF_MAN] = s_r.man;
        rdm[CF_FILT+:4] = s_r.filt;
      end
      A_TB: rdm = {8'h00, s_r.tb};
      A_SCAL: rdm = {8'h00, s_r.scal};
      A_DIV: rdm = {16'h0000, s_r.divi};
      A_PRE: rdm = {8'h00, s_r.preset};
      A_DLY: rdm = {8'h00, s_r.dly};
      A_DB: rdm = {8'h00, s_r.db};
      A_SP0: rdm = {8'h00, s_r.sp[0]};
      A_SP1: rdm = {8'h00, s_r.sp[1]};
      A_SP2: rdm = {8'h00, s_r.sp[2]};
      A_PV: rdm = {8'h00, pv};
      A_RATE: rdm = {8'h00, rate_out};
      A_HI: rdm = {8'h00, s_r.hi};
      A_LO: rdm = {8'h00, s_r.lo};
      A_STAT: begin
        rdm[ST_LIM+:3] = s_r.lim;
        rdm[ST_OVR] = pv == OVR;
        rdm[ST_FLO] = s_r.flo;
        rdm[ST_DLY] = s_r.dly_on;
        rdm[ST_VLO] = s_r.vlo;
      end
      default: rdm = {8'h00, s_r.freq};
    endcase
    s_nxt.rdata = rd_en ? rdm : '0;
  end
  // single state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
      s_r.tb <= TB_RST;
      s_r.divi <= DIV_RST;
      s_r.dly <= DLY_RST;
      s_r.sp <= {3{VAL_MAX}};
      s_r.lo <= VAL_MAX;
      s_r.vlo <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign rd_data = s_r.rdata;
  assign relay_out = s_r.lim[1:0];
  assign alarm_out = s_r.lim[2];
  assign limit_led = s_r.lim;
  assign high_peak_prompt = s_r.s2[1] & ~s_r.vlo;
  assign low_peak_prompt = s_r.s2[1] & s_r.vlo;
  assign over_range = pv == OVR;

endmodule

//--- design/pcm_pkg.sv
package pcm_pkg;
  // clock and time base
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned MS_NS = 1_000_000;
  localparam int unsigned MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned S_MS = 1000;
  localparam logic [9:0] SEC_LAST = 10'h3E7;
  localparam logic [15:0] MS_PER_S = 16'h03E8;
  // value range; OVR is the over-range marker one above the top
  localparam logic [23:0] VAL_MAX = 24'h98_967F;
  localparam logic [23:0] OVR = 24'h98_9680;
  localparam logic [23:0] TB_MIN = 24'h00_03E8;
  localparam logic [23:0] SC_ONE = 24'h01_86A0;
  localparam logic [23:0] LO_MIN = 24'h00_00C8;
  localparam logic [23:0] LO_MAX = 24'h00_C350;
  localparam logic [23:0] HI_MAX = 24'h0F_4240;
  localparam logic [35:0] FNUM_HI = 36'h0_0EE6_B280;
  localparam logic [35:0] FNUM_LO = 36'h5_D21D_BA00;
  localparam logic [5:0] DIV_LAST = 6'h23;
  // register indices
  localparam logic [3:0] A_CTRL = 4'h0;
  localparam logic [3:0] A_TB = 4'h1;
  localparam logic [3:0] A_SCAL = 4'h2;
  localparam logic [3:0] A_DIV = 4'h3;
  localparam logic [3:0] A_PRE = 4'h4;
  localparam logic [3:0] A_DLY = 4'h5;
  localparam logic [3:0] A_DB = 4'h6;
  localparam logic [3:0] A_SP0 = 4'h7;
  localparam logic [3:0] A_SP1 = 4'h8;
  localparam logic [3:0] A_SP2 = 4'h9;
  localparam logic [3:0] A_PV = 4'hA;
  localparam logic [3:0] A_RATE = 4'hB;
  localparam logic [3:0] A_HI = 4'hC;
  localparam logic [3:0] A_LO = 4'hD;
  localparam logic [3:0] A_STAT = 4'hE;
  localparam logic [3:0] A_FREQ = 4'hF;
  // control and status fields
  localparam int CF_MODE = 0;
  localparam int CF_FLO = 2;
  localparam int CF_CM = 3;
  localparam int CF_MAN = 6;
  localparam int CF_FILT = 7;
  localparam int CF_LCLR = 11;
  localparam int ST_LIM = 0;
  localparam int ST_OVR = 3;
  localparam int ST_FLO = 4;
  localparam int ST_DLY = 5;
  localparam int ST_VLO = 6;
  localparam logic [2:0] CM_MAX = 3'h5;
  localparam logic [2:0] CM_DOWN = 3'h3;
  localparam logic [3:0] FILT_MAX = 4'h8;
  // reset values
  localparam logic [23:0] TB_RST = 24'h00_03E8;
  localparam logic [15:0] DIV_RST = 16'h0001;
  localparam logic [23:0] DLY_RST = 24'h00_0001;

  typedef enum logic [1:0] {M_RATE, M_RPM, M_FREQ, M_COUNT} mode_t;
  typedef enum logic {D_IDLE, D_RUN} dstate_t;
endpackage

//--- verif/pcm_sva.sv
`timescale 1ns/1ps
module pcm_sva
  import pcm_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [3:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rd_data,
  input wire logic pulse_in,
  input wire logic peak_view_key,
  input wire logic reset_key,
  input wire logic [1:0] relay_out,
  input wire logic alarm_out,
  input wire logic [2:0] limit_led,
  input wire logic high_peak_prompt,
  input wire logic low_peak_prompt
);
  logic man_r;
  logic quiet_r;
  logic pulse_q_r;
  logic [3:0] act_age_r;
  logic [3:0] clr_age_r;
  // mirror of stored mode bits and age of the last possible limit cause
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      man_r <= 1'b0;
      quiet_r <= 1'b0;
      pulse_q_r <= 1'b0;
      act_age_r <= 4'h0;
      clr_age_r <= 4'h0;
    end else begin
      pulse_q_r <= pulse_in;
      // only counter modes without a delay timer stay still on their own
      if (wr_en && addr == A_CTRL) begin
        man_r <= wr_data[CF_MAN];
        quiet_r <= wr_data[1:0] == 2'h3 && wr_data[5:3] != 3'h2 &&
          wr_data[5:3] < CM_MAX;
      end
      if (wr_en || reset_key || pulse_in != pulse_q_r)
        act_age_r <= 4'h0;
      else if (act_age_r != 4'hF)
        act_age_r <= act_age_r + 4'h1;
      if ((wr_en && addr == A_CTRL) || reset_key)
        clr_age_r <= 4'h0;
      else if (clr_age_r != 4'hF)
        clr_age_r <= clr_age_r + 4'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  chk_rd_idle: assert property (
    !$past(rd_en) |-> rd_data == 32'h0000_0000)
    else $error("read data outside the answer cycle");
  chk_alarm_led: assert property (
    alarm_out == limit_led[2]) else $error("alarm and led differ");
  chk_relay_led: assert property (
    relay_out == limit_led[1:0]) else $error("relay and led differ");
  chk_prompt_one: assert property (
    !(high_peak_prompt && low_peak_prompt))
    else $error("both peak prompts shown");
  chk_prompt_key: assert property (
    (high_peak_prompt || low_peak_prompt) |-> $past(peak_view_key, 2) ||
    $past(peak_view_key, 3) || $past(peak_view_key, 4))
    else $error("peak prompt without the key");
  chk_prompt_drop: assert property (
    !peak_view_key [*4] |=> !high_peak_prompt && !low_peak_prompt)
    else $error("peak prompt stays after key release");
  chk_man_hold: assert property (
    man_r && |($past(limit_led) & ~limit_led) |-> clr_age_r < 4'hF)
    else $error("latched limit fell without a clear");
  chk_lim_quiet: assert property (
    quiet_r && act_age_r == 4'hF |-> $stable(limit_led))
    else $error("limit moved with no input activity");
endmodule

//--- verif/pulse_source.sv
`timescale 1ns/1ps
module pulse_source (
  input wire logic clk,
  output logic pulse_in
);
  int per = 8;
  int left = 0;
  int ph = 0;
  // line idles low between bursts; a negative count runs free
  always @(posedge clk) begin
    if (left != 0) begin
      ph <= (ph + 1) % per;
      pulse_in <= ph < per / 2;
      if (ph == per - 1 && left > 0)
        left <= left - 1;
    end else begin
      ph <= 0;
      pulse_in <= 1'b0;
    end
  end
  // lands just off the clock edge like every other bench driver
  task automatic burst(input int n, input int p);
    per <= p;
    left <= n;
  endtask
  initial pulse_in = 1'b0;
endmodule

//--- verif/pulse_channel_monitor_test.sv
`timescale 1ns/1ps
module pulse_channel_monitor_test
  import pcm_pkg::*;
();
  localparam logic [31:0] CNT_AUTO = 32'h0000_0003;
  localparam logic [31:0] CNT_MAN = 32'h0000_0043;
  logic clk, arst_n, wr_en, rd_en, pulse_in, peak_view_key, reset_key;
  logic channel_select_key, ch1_pulse, alarm_out, over_range;
  logic high_peak_prompt, low_peak_prompt;
  logic [3:0] addr;
  logic [31:0] wr_data, rd_data, v;
  logic [1:0] relay_out;
  logic [2:0] limit_led;
  int error_cnt = 0;
  int checks = 0;
  int seed = 30117;
  int n, p;
  int periods [4] = '{500, 1000, 1250, 2000};
  logic [3:0] ra [6] = '{A_TB, A_DIV, A_SP0, A_HI, A_LO, A_DLY};
  // low peak already follows the idle rate of zero after reset
  logic [23:0] rv [6] = '{TB_RST, {8'h00, DIV_RST}, VAL_MAX,
    24'h00_0000, 24'h00_0000, DLY_RST};
  // short tick and timeout so the whole run stays small
  localparam int SIM_MS = 10;
  localparam int SIM_TO = 5000;
  pulse_channel_monitor #(.MS_CYCLES(SIM_MS), .FREQ_TO_CYC(SIM_TO)) i_dut (
    .clk, .arst_n, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .pulse_in,
    .peak_view_key, .reset_key, .channel_select_key, .ch1_pulse,
    .relay_out, .alarm_out, .limit_led, .high_peak_prompt,
    .low_peak_prompt, .over_range);
  pulse_source i_src (.clk, .pulse_in);
  // free running clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [31:0] freq_exp(input int per);
    return 32'(FNUM_HI / per);
  endfunction
  // a one second window always holds a whole number of periods
  function automatic logic [31:0] edges_exp(input int per);
    return 32'(S_MS * SIM_MS / per);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // every task returns just off the clock edge
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 v = rd_data;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
    rd(a);
    chk(v, e);
  endtask
  task automatic pulses(input int k, input int per);
    i_src.burst(k, per);
    tick(2);
    for (int i = 0; i < 5000 && i_src.left != 0; i++)
      @(posedge clk);
    tick(8);
  endtask
  task automatic peak_reset(input logic hi);
    peak_view_key <= 1'b1;
    tick(6);
    chk(32'(hi ? high_peak_prompt : low_peak_prompt), 1);
    reset_key <= 1'b1;
    tick(6);
    reset_key <= 1'b0;
    peak_view_key <= 1'b0;
    tick(6);
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic print_verdict();
    $display("counts: %0d checks, %0d mismatches", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // a hang counts as a mismatch
  initial begin
    #300000;
    error_cnt++;
    $display("unexpected at %0t: watchdog expired", $time);
    print_verdict();
  end
  // main sequence
  initial begin
    arst_n = 1'b0;
    addr = 4'h0;
    wr_data = 32'h0000_0000;
    {wr_en, rd_en, peak_view_key, reset_key} = 4'h0;
    {channel_select_key, ch1_pulse} = 2'h0;
    tick(5);
    arst_n <= 1'b1;
    tick(2);
    for (int i = 0; i < 6; i++)
      rdchk(ra[i], {8'h00, rv[i]});
    wr(A_TB, 32'h0000_0005);
    rdchk(A_TB, {8'h00, TB_MIN});
    wr(A_TB, 32'h0098_9680);
    rdchk(A_TB, {8'h00, VAL_MAX});
    wr(A_TB, 32'h0000_04D2);
    rdchk(A_TB, 32'h0000_04D2);
    wr(A_SP1, 32'h0000_0000);
    rdchk(A_SP1, 32'h0000_0001);
    wr(A_SCAL, 32'h00FF_FFFF);
    rdchk(A_SCAL, {8'h00, VAL_MAX});
    wr(A_CTRL, 32'h0000_0188);
    wr(A_CTRL, 32'h0000_04B8);
    rd(A_CTRL);
    chk(32'(v[10:3]), 32'h0000_0031);
    done("registers");
    n = 3 + ($random(seed) & 7);
    p = 4 + ($random(seed) & 7);
    wr(A_SCAL, 32'h0000_0000);
    wr(A_CTRL, CNT_AUTO);
    wr(A_SP0, 32'(n - 1));
    wr(A_SP1, 32'(n));
    pulses(n, p);
    rdchk(A_PV, 32'(n));
    chk(32'(limit_led), 32'h0000_0001);
    wr(A_DIV, 32'h0000_0003);
    wr(A_CTRL, CNT_AUTO);
    pulses(7, p);
    rdchk(A_PV, 32'h0000_0002);
    wr(A_SCAL, 32'h0003_D090);
    wr(A_CTRL, CNT_AUTO);
    pulses(4, p);
    rdchk(A_PV, 32'h0000_000A);
    done("count and scale");
    wr(A_SCAL, 32'h0000_0000);
    wr(A_DIV, 32'h0000_0001);
    wr(A_CTRL, CNT_AUTO);
    pulses(2, p);
    peak_reset(1'b1);
    rdchk(A_HI, 32'h0000_0002);
    peak_reset(1'b0);
    rdchk(A_LO, 32'h0000_0002);
    done("peaks");
    wr(A_DB, 32'h0000_0002);
    wr(A_CTRL, CNT_AUTO);
    wr(A_SP0, 32'h0000_0001);
    pulses(3, p);
    chk(32'(relay_out), 32'h0000_0001);
    wr(A_SP0, 32'h0000_0005);
    tick(4);
    chk(32'(relay_out), 32'h0000_0001);
    wr(A_SP0, 32'h0000_0006);
    tick(4);
    chk(32'(relay_out), 32'h0000_0000);
    wr(A_DB, 32'h0000_0000);
    wr(A_CTRL, CNT_MAN);
    wr(A_SP0, 32'h0000_0001);
    pulses(3, p);
    wr(A_SP0, {8'h00, VAL_MAX});
    tick(4);
    chk(32'(relay_out), 32'h0000_0001);
    channel_select_key <= 1'b1;
    tick(6);
    reset_key <= 1'b1;
    tick(6);
    {channel_select_key, reset_key} <= 2'h0;
    tick(6);
    chk(32'(relay_out), 32'h0000_0000);
    rdchk(A_PV, 32'h0000_0000);
    done("limits");
    wr(A_CTRL, 32'h0000_0001);
    i_src.burst(-1, 100);
    tick(2 * S_MS * SIM_MS + 200);
    rdchk(A_RATE, edges_exp(100));
    rdchk(A_PV, edges_exp(100) * 32'h0000_003C);
    i_src.burst(0, 100);
    done("rpm");
    p = periods[$random(seed) & 3];
    wr(A_CTRL, 32'h0000_0002);
    tick(SIM_TO + 50);
    rdchk(A_FREQ, 32'h0000_0000);
    peak_reset(1'b1);
    rdchk(A_HI, 32'h0000_0000);
    i_src.burst(-1, p);
    tick(p * 4 + 200);
    rdchk(A_FREQ, freq_exp(p));
    rdchk(A_RATE, freq_exp(p));
    rdchk(A_HI, freq_exp(p));
    ch1_pulse <= 1'b1;
    wr(A_CTRL, 32'h0000_0006);
    tick(p * 4 + 200);
    rd(A_STAT);
    chk(32'(v[ST_FLO]), 32'h0000_0000);
    rdchk(A_FREQ, freq_exp(p));
    ch1_pulse <= 1'b0;
    wr(A_CTRL, 32'h0000_0006);
    tick(p * 4 + 200);
    rdchk(A_FREQ, {8'h00, OVR});
    rd(A_STAT);
    chk(32'(v[ST_FLO]), 32'h0000_0001);
    ch1_pulse <= 1'b1;
    tick(4);
    rd(A_STAT);
    chk(32'(v[ST_FLO]), 32'h0000_0000);
    i_src.burst(0, p);
    done("frequency");
    print_verdict();
  end
endmodule
bind pulse_channel_monitor pcm_sva i_sva (
  .clk, .arst_n, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .pulse_in,
  .peak_view_key, .reset_key, .relay_out, .alarm_out, .limit_led,
  .high_peak_prompt, .low_peak_prompt);
